// File: hw/iosc_pkg.sv
// constants shared by the internal oscillator control block
// assumes a single 125 MHz bus clock drives every register of the block

package iosc_pkg;

  // ---------------------------------------------------------------
  // clock rate and start-up times
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned HF_STARTUP_NS = 2000;
  localparam int unsigned LF_STARTUP_NS = 2000;
  // least times round up to whole cycles
  localparam int unsigned HF_STARTUP_CYC = (HF_STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LF_STARTUP_CYC = (LF_STARTUP_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h0C;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned FSEL_LSB = 4;
  localparam int unsigned BUSY_BIT = 3;
  localparam int unsigned HF_OK_BIT = 2;
  localparam int unsigned LF_OK_BIT = 1;
  localparam int unsigned SRC_SEL_BIT = 0;
  localparam logic [2:0] FSEL_RST = 3'h6;
  localparam logic SRC_SEL_RST = 1'b0;
  localparam int unsigned OSF_BIT = 7;
  localparam int unsigned C2_BIT = 6;
  localparam int unsigned C1_BIT = 5;
  localparam int unsigned EE_BIT = 4;
  localparam logic [7:0] IRQ_EN_MASK = 8'hF0;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam int unsigned GATE_BIT = 6;

  // ---------------------------------------------------------------
  // clock source indices
  // ---------------------------------------------------------------
  localparam int unsigned NSRC = 9;
  localparam int unsigned DIV_W = 6;
  localparam logic [3:0] SRC_LF = 4'h0;
  localparam logic [3:0] SRC_EXT = 4'h8;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_START,
    SW_FALL,
    SW_RISE
  } iosc_sw_state_t;

endpackage

// File: hw/iosc_sw_if.sv
// bundle between the oscillator control top and its clock switcher
// assumes both ends run on the same bus clock

`timescale 1ns/1ps

interface iosc_sw_if;
  logic [8:0] src;
  logic [3:0] tgt_req;
  logic req;
  logic tgt_ready;
  logic busy;
  logic [3:0] cur;
  logic [3:0] tgt;
  logic done;
  logic clk_out;

  modport ctl (
    output src,
    output tgt_req,
    output req,
    output tgt_ready,
    input busy,
    input cur,
    input tgt,
    input done,
    input clk_out
  );

  modport sw (
    input src,
    input tgt_req,
    input req,
    input tgt_ready,
    output busy,
    output cur,
    output tgt,
    output done,
    output clk_out
  );
endinterface

// File: hw/iosc_clk_switch.sv
// glitch-free clock switcher: old clock low edge, then new clock high edge
// assumes source levels arrive already synchronised to hclk

`timescale 1ns/1ps

module iosc_clk_switch (
  input wire logic hclk,
  input wire logic hresetn,
  iosc_sw_if.sw sw
);

  iosc_pkg::iosc_sw_state_t state_q;
  logic [3:0] cur_q;
  logic [3:0] tgt_q;
  logic clk_q;
  logic done_q;
  logic cur_prev_q;
  logic tgt_prev_q;
  logic cur_lvl;
  logic tgt_lvl;

  assign cur_lvl = sw.src[cur_q];
  assign tgt_lvl = sw.src[tgt_q];
  assign sw.busy = (state_q != iosc_pkg::SW_IDLE);
  assign sw.cur = cur_q;
  assign sw.tgt = tgt_q;
  assign sw.done = done_q;
  assign sw.clk_out = clk_q;

  // previous levels for edge detection on old and new clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_prev_q <= 1'b0;
      tgt_prev_q <= 1'b0;
    end else begin
      cur_prev_q <= cur_lvl;
      tgt_prev_q <= tgt_lvl;
    end
  end

  // switch sequence; clock output never shows a runt pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= iosc_pkg::SW_IDLE;
      cur_q <= iosc_pkg::SRC_EXT;
      tgt_q <= iosc_pkg::SRC_EXT;
      clk_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        iosc_pkg::SW_IDLE: begin
          clk_q <= cur_lvl;
          if (sw.req) begin
            tgt_q <= sw.tgt_req;
            state_q <= iosc_pkg::SW_START;
          end
        end
        iosc_pkg::SW_START: begin
          clk_q <= cur_lvl;
          if (sw.tgt_ready) begin
            state_q <= iosc_pkg::SW_FALL;
          end
        end
        iosc_pkg::SW_FALL: begin
          if (cur_prev_q && !cur_lvl) begin
            clk_q <= 1'b0;
            state_q <= iosc_pkg::SW_RISE;
          end else begin
            clk_q <= cur_lvl;
          end
        end
        iosc_pkg::SW_RISE: begin
          if (!tgt_prev_q && tgt_lvl) begin
            cur_q <= tgt_q;
            clk_q <= 1'b1;
            done_q <= 1'b1;
            state_q <= iosc_pkg::SW_IDLE;
          end else begin
            clk_q <= 1'b0;
          end
        end
        default: begin
          state_q <= iosc_pkg::SW_IDLE;
          clk_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: hw/iosc_top.sv
// internal oscillator control: frequency select, oscillator enables,
// stable flags, glitch-free clock switch and peripheral irq enables
// assumes an AHB-Lite master on hclk and raw oscillator outputs on pins

`timescale 1ns/1ps

// Behaviour
// - low oscillator also feeds timer timebase
// - low osc on for 31k select or timers
// - two-speed startup with 000 enables low osc
// - read-only low oscillator stable flag
// - three-bit select picks one of eight
// - reset loads select with 110, 4 MHz
// - stopped target oscillator waits start-up delay
// - wait old clock falling edge first
// - hold low until new clock rises
// - stable flags update when new clock connects
// - postscaler choices switch without start-up delay
// - enable register bits 7-4, low bits zero
// - global peripheral gate blocks every interrupt
module iosc_top #(
  parameter int unsigned HF_STARTUP_CYC = iosc_pkg::HF_STARTUP_CYC,
  parameter int unsigned LF_STARTUP_CYC = iosc_pkg::LF_STARTUP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic hf_osc_clk,
  input wire logic lf_osc_clk,
  input wire logic ext_clk,
  input wire logic two_speed_startup_en,
  input wire logic powerup_timer_en,
  input wire logic watchdog_timer_en,
  input wire logic failsafe_clock_monitor_en,
  input wire logic osc_fail_evt,
  input wire logic comparator2_evt,
  input wire logic comparator1_evt,
  input wire logic eeprom_write_evt,
  output logic hf_osc_en,
  output logic lf_osc_en,
  output logic lf_timebase,
  output logic clock_output,
  output logic irq
);

  localparam int unsigned HW = $clog2(HF_STARTUP_CYC + 1);
  localparam int unsigned LW = $clog2(LF_STARTUP_CYC + 1);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  generate
    if (HF_STARTUP_CYC < 1 || LF_STARTUP_CYC < 1) begin : g_bad_cyc
      $error("start-up counts must be at least one cycle");
    end
  endgenerate

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  iosc_sw_if swi ();

  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic hf_prev_q;
  logic [iosc_pkg::DIV_W-1:0] div_q;
  logic [8:0] src;
  logic [2:0] fsel_q;
  logic scs_q;
  logic [7:0] irq_en_q;
  logic [7:0] stat_q;
  logic gate_q;
  logic lf_stable_q;
  logic hf_stable_q;
  logic [HW-1:0] hf_cnt_q;
  logic [LW-1:0] lf_cnt_q;
  logic hf_ready;
  logic lf_ready;
  logic [3:0] want_idx;
  logic lf_need;
  logic hf_need;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic hf_en_q;
  logic lf_en_q;
  logic lf_tb_q;
  logic clk_out_q;
  logic irq_q;
  logic [7:0] evt;
  logic [7:0] w1c;
  logic addr_ok;
  logic [31:0] rd_word;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // oscillator outputs and the external clock are asynchronous to hclk;
  // first stage feeds only the second stage
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_s1_q[i] <= 1'b0;
          pin_s2_q[i] <= 1'b0;
        end else begin
          pin_s1_q[i] <= (i == 0) ? hf_osc_clk : ((i == 1) ? lf_osc_clk : ext_clk);
          pin_s2_q[i] <= pin_s1_q[i];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // postscaler
  // ---------------------------------------------------------------
  // ripple-free binary divider advanced on each high oscillator rise;
  // the 8 MHz rate needs the pin sampled well above twice its rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hf_prev_q <= 1'b0;
      div_q <= '0;
    end else begin
      hf_prev_q <= pin_s2_q[0];
      if (pin_s2_q[0] && !hf_prev_q) begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // source map: 0 low osc, 7 high osc, 6..1 halving taps, 8 external
  assign src[0] = pin_s2_q[1];
  assign src[7] = pin_s2_q[0];
  assign src[8] = pin_s2_q[2];
  generate
    for (genvar k = 1; k < 7; k++) begin : g_tap
      assign src[k] = div_q[6-k];
    end
  endgenerate

  // ---------------------------------------------------------------
  // oscillator enables and start-up delay
  // ---------------------------------------------------------------
  // requested source: select code when the source bit is set
  assign want_idx = scs_q ? {1'b0, fsel_q} : iosc_pkg::SRC_EXT;

  // low osc also runs while it is the current or pending switch source
  always_comb begin
    lf_need = (scs_q && fsel_q == 3'h0) || powerup_timer_en || watchdog_timer_en ||
      failsafe_clock_monitor_en;
    if (two_speed_startup_en && fsel_q == 3'h0) begin
      lf_need = 1'b1;
    end
    if (swi.cur == iosc_pkg::SRC_LF || (swi.busy && swi.tgt == iosc_pkg::SRC_LF)) begin
      lf_need = 1'b1;
    end
    hf_need = (want_idx != iosc_pkg::SRC_LF && want_idx != iosc_pkg::SRC_EXT) ||
      (swi.cur != iosc_pkg::SRC_LF && swi.cur != iosc_pkg::SRC_EXT) ||
      (swi.busy && swi.tgt != iosc_pkg::SRC_LF && swi.tgt != iosc_pkg::SRC_EXT);
  end

  // registered enables drive the analog oscillator cells
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hf_en_q <= 1'b0;
      lf_en_q <= 1'b0;
    end else begin
      hf_en_q <= hf_need;
      lf_en_q <= lf_need;
    end
  end

  // start-up counters restart whenever an oscillator is shut down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hf_cnt_q <= '0;
      lf_cnt_q <= '0;
    end else begin
      if (!hf_en_q) begin
        hf_cnt_q <= '0;
      end else if (!hf_ready) begin
        hf_cnt_q <= hf_cnt_q + 1'b1;
      end
      if (!lf_en_q) begin
        lf_cnt_q <= '0;
      end else if (!lf_ready) begin
        lf_cnt_q <= lf_cnt_q + 1'b1;
      end
    end
  end

  assign hf_ready = (hf_cnt_q == HW'(HF_STARTUP_CYC));
  assign lf_ready = (lf_cnt_q == LW'(LF_STARTUP_CYC));

  // ---------------------------------------------------------------
  // clock switch
  // ---------------------------------------------------------------
  // a postscaler target while the high osc already runs is ready at once
  assign swi.src = src;
  assign swi.tgt_req = want_idx;
  assign swi.req = (want_idx != swi.cur);
  assign swi.tgt_ready = (swi.tgt == iosc_pkg::SRC_EXT) ? 1'b1 :
    ((swi.tgt == iosc_pkg::SRC_LF) ? lf_ready : hf_ready);

  iosc_clk_switch u_switch (
    .hclk(hclk),
    .hresetn(hresetn),
    .sw(swi.sw)
  );

  // stable flags follow the switch; a stopped oscillator clears at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lf_stable_q <= 1'b0;
      hf_stable_q <= 1'b0;
    end else begin
      if (!lf_en_q) begin
        lf_stable_q <= 1'b0;
      end else if (swi.done || !swi.busy) begin
        lf_stable_q <= lf_ready;
      end
      if (!hf_en_q) begin
        hf_stable_q <= 1'b0;
      end else if (swi.done || !swi.busy) begin
        hf_stable_q <= hf_ready;
      end
    end
  end

  // clock output one flop after the switcher, timebase one flop after the low osc synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_out_q <= 1'b0;
      lf_tb_q <= 1'b0;
    end else begin
      clk_out_q <= swi.clk_out;
      lf_tb_q <= lf_en_q & pin_s2_q[1];
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  // writes finish with no wait state; reads insert one so that a read
  // right behind a write sees the written value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= 1'b0;
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hrdata_q <= rd_word;
        hreadyout_q <= 1'b1;
      end else if (hsel && htrans[1] && hready) begin
        addr_q <= haddr[7:0];
        wr_pend_q <= hwrite;
        rd_pend_q <= !hwrite;
        hreadyout_q <= hwrite;
      end
    end
  end

  assign addr_ok = (addr_q[1:0] == 2'b00);

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (addr_ok) begin
      case (addr_q)
        iosc_pkg::OFS_OSC_CTRL: begin
          rd_word[iosc_pkg::FSEL_LSB +: 3] = fsel_q;
          rd_word[iosc_pkg::BUSY_BIT] = swi.busy;
          rd_word[iosc_pkg::HF_OK_BIT] = hf_stable_q;
          rd_word[iosc_pkg::LF_OK_BIT] = lf_stable_q;
          rd_word[iosc_pkg::SRC_SEL_BIT] = scs_q;
        end
        iosc_pkg::OFS_IRQ_EN: rd_word[7:0] = irq_en_q & iosc_pkg::IRQ_EN_MASK;
        iosc_pkg::OFS_IRQ_STAT: rd_word[7:0] = stat_q;
        iosc_pkg::OFS_IRQ_CTRL: rd_word[iosc_pkg::GATE_BIT] = gate_q;
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // stable flags and busy are not writable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fsel_q <= iosc_pkg::FSEL_RST;
      scs_q <= iosc_pkg::SRC_SEL_RST;
      irq_en_q <= iosc_pkg::IRQ_EN_RST;
      gate_q <= 1'b0;
    end else if (wr_pend_q && addr_ok) begin
      case (addr_q)
        iosc_pkg::OFS_OSC_CTRL: begin
          fsel_q <= hwdata[iosc_pkg::FSEL_LSB +: 3];
          scs_q <= hwdata[iosc_pkg::SRC_SEL_BIT];
        end
        iosc_pkg::OFS_IRQ_EN: irq_en_q <= hwdata[7:0] & iosc_pkg::IRQ_EN_MASK;
        iosc_pkg::OFS_IRQ_CTRL: gate_q <= hwdata[iosc_pkg::GATE_BIT];
        default: gate_q <= gate_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and output
  // ---------------------------------------------------------------
  always_comb begin
    evt = 8'h00;
    evt[iosc_pkg::OSF_BIT] = osc_fail_evt;
    evt[iosc_pkg::C2_BIT] = comparator2_evt;
    evt[iosc_pkg::C1_BIT] = comparator1_evt;
    evt[iosc_pkg::EE_BIT] = eeprom_write_evt;
    w1c = 8'h00;
    if (wr_pend_q && addr_ok && addr_q == iosc_pkg::OFS_IRQ_STAT) begin
      w1c = hwdata[7:0] & iosc_pkg::IRQ_EN_MASK;
    end
  end

  // sticky bits; an event in the clearing cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 8'h00;
    end else begin
      stat_q <= (stat_q & ~w1c) | evt;
    end
  end

  // level output, masked per source and by the global gate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= gate_q && |(stat_q & irq_en_q);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hf_osc_en = hf_en_q;
  assign lf_osc_en = lf_en_q;
  assign lf_timebase = lf_tb_q;
  assign clock_output = clk_out_q;
  assign irq = irq_q;

endmodule

// File: bench/iosc_top_assertions.sv
// concurrent checks on the oscillator control top ports
// assumes one hclk domain and hresetn asynchronous, active low

`timescale 1ns/1ps

module iosc_top_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic powerup_timer_en,
  input wire logic watchdog_timer_en,
  input wire logic failsafe_clock_monitor_en,
  input wire logic osc_fail_evt,
  input wire logic comparator2_evt,
  input wire logic comparator1_evt,
  input wire logic eeprom_write_evt,
  input wire logic lf_osc_en,
  input wire logic lf_timebase,
  input wire logic irq
);
  // -------------------------------------------------------------
  // helper terms
  // -------------------------------------------------------------
  wire logic take = hsel & htrans[1] & hready;
  wire logic wtake = take & hwrite;
  wire logic rtake = take & ~hwrite;
  wire logic evt = osc_fail_evt | comparator2_evt | comparator1_evt | eeprom_write_evt;
  wire logic tmr = powerup_timer_en | watchdog_timer_en | failsafe_clock_monitor_en;
  logic seen_q;

  // remembers any event since reset; irq cannot exist before one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_q <= 1'b0;
    end else if (evt) begin
      seen_q <= 1'b1;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  a_read_one_wait: assert property (rtake |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not exactly one wait");
  a_write_no_wait: assert property (wtake |=> hreadyout)
    else $error("write data phase stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property (!$stable(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside read completion");
  a_timer_lf_on: assert property (tmr |=> lf_osc_en)
    else $error("timer enabled but low osc off");
  a_timebase_gated: assert property (!lf_osc_en [*2] |-> !lf_timebase)
    else $error("timebase runs with low osc off");
  a_irq_needs_event: assert property (!seen_q |-> !irq)
    else $error("irq without any event");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(evt, 2) || $past(wtake, 3))
    else $error("irq rose without event or write");
  a_irq_fall_clear: assert property ($fell(irq) |-> $past(wtake, 3))
    else $error("irq fell without a write");

  c_read: cover property (rtake);
  c_irq: cover property ($rose(irq));
  c_lf_on: cover property ($rose(lf_osc_en));
endmodule

bind iosc_top iosc_top_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .powerup_timer_en(powerup_timer_en),
  .watchdog_timer_en(watchdog_timer_en), .failsafe_clock_monitor_en(failsafe_clock_monitor_en),
  .osc_fail_evt(osc_fail_evt), .comparator2_evt(comparator2_evt),
  .comparator1_evt(comparator1_evt), .eeprom_write_evt(eeprom_write_evt),
  .lf_osc_en(lf_osc_en), .lf_timebase(lf_timebase), .irq(irq));

// File: bench/iosc_top_tb_top.sv
// self-checking bench for the oscillator control top
// assumes the checker is bound in; start-up counts shortened to 4

`timescale 1ns/1ps

module iosc_top_tb_top;
  logic hclk, hresetn, hsel, hwrite, hf, lf, ext, ts;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] tmr;
  logic [3:0] evt;
  logic hreadyout, hresp, hf_osc_en, lf_osc_en, lf_timebase, clock_output, irq;
  int failures, cmp_count, run;

  iosc_top #(.HF_STARTUP_CYC(4), .LF_STARTUP_CYC(4)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .hf_osc_clk(hf), .lf_osc_clk(lf), .ext_clk(ext),
    .two_speed_startup_en(ts), .powerup_timer_en(tmr[0]), .watchdog_timer_en(tmr[1]),
    .failsafe_clock_monitor_en(tmr[2]), .osc_fail_evt(evt[3]), .comparator2_evt(evt[2]),
    .comparator1_evt(evt[1]), .eeprom_write_evt(evt[0]), .hf_osc_en(hf_osc_en),
    .lf_osc_en(lf_osc_en), .lf_timebase(lf_timebase), .clock_output(clock_output), .irq(irq));

  // -------------------------------------------------------------
  // clocks: bus 125 MHz, oscillators free running, unrelated phase
  // -------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    hf = 1'b0;
    forever #62.5 hf = ~hf;
  end
  initial begin
    lf = 1'b0;
    forever #16000 lf = ~lf;
  end
  initial begin
    ext = 1'b0;
    forever #40 ext = ~ext;
  end

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic bad(input string m);
    failures++;
    $display("Error at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad($sformatf("word %h expected %h", got, exp));
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad($sformatf("bit %b expected %b", got, exp));
    end
  endtask

  // hready sampled at negedge: same value the next rising edge sees
  task automatic rdy();
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(negedge hclk);
    end
    if (n >= 50) begin
      bad("bus hang");
      give_verdict();
    end
    @(posedge hclk);
  endtask

  task automatic aph(input logic [7:0] a, input logic w);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aph(a, 1'b1);
    hwdata <= d;
    rdy();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    aph(a, 1'b0);
    rdy();
    d = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask

  // switch completion polled through the busy bit, bounded
  task automatic wait_sw();
    logic [31:0] v;
    int n;
    n = 0;
    do begin
      rd(iosc_pkg::OFS_OSC_CTRL, v);
      n++;
    end while (v[iosc_pkg::BUSY_BIT] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      bad("switch hang");
      give_verdict();
    end
  endtask

  // switched clock must keep toggling once a switch is complete
  task automatic clk_toggles();
    for (int k = 0; k < 40 && clock_output !== 1'b1; k++) begin
      @(negedge hclk);
    end
    chkb(clock_output, 1'b1);
    for (int k = 0; k < 40 && clock_output !== 1'b0; k++) begin
      @(negedge hclk);
    end
    chkb(clock_output, 1'b0);
  endtask

  task automatic pulse(input int i);
    @(posedge hclk);
    evt <= 4'h1 << i;
    @(posedge hclk);
    evt <= 4'h0;
  endtask

  // a switched clock never shows a high pulse shorter than 3 hclk samples
  always @(negedge hclk) begin
    if (!hresetn || clock_output !== 1'b1) begin
      if (hresetn && run > 0 && run < 3) begin
        bad("clock output glitch");
      end
      run = 0;
    end else begin
      run++;
    end
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, ts, tmr, evt, htrans, run} = '0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    failures = 0;
    cmp_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(iosc_pkg::OFS_OSC_CTRL, 32'h00000060);
    tick(1);
    chkb(lf_osc_en, 1'b0);
    rd_chk(iosc_pkg::OFS_IRQ_EN, 32'h00000000);
    wr(iosc_pkg::OFS_IRQ_EN, 32'hFFFFFFFF);
    rd_chk(iosc_pkg::OFS_IRQ_EN, 32'h000000F0);
    wr(8'h10, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'h00000000);
    // stopped high osc: start-up, then switch to 8 MHz
    wr(iosc_pkg::OFS_OSC_CTRL, 32'h00000071);
    tick(2);
    chkb(hf_osc_en, 1'b1);
    wait_sw();
    rd_chk(iosc_pkg::OFS_OSC_CTRL, 32'h00000075);
    clk_toggles();
    // undivided high osc to postscaler tap 1, high osc never stops
    wr(iosc_pkg::OFS_OSC_CTRL, 32'h00000011);
    rd_chk(iosc_pkg::OFS_OSC_CTRL, 32'h0000001D);
    wait_sw();
    rd_chk(iosc_pkg::OFS_OSC_CTRL, 32'h00000015);
    // to 31 kHz: low osc runs, high osc stops
    wr(iosc_pkg::OFS_OSC_CTRL, 32'h00000001);
    wait_sw();
    rd_chk(iosc_pkg::OFS_OSC_CTRL, 32'h00000003);
    tick(1);
    chkb(lf_osc_en, 1'b1);
    chkb(hf_osc_en, 1'b0);
    // back to the configured source, then two-speed start-up
    wr(iosc_pkg::OFS_OSC_CTRL, 32'h00000000);
    wait_sw();
    rd_chk(iosc_pkg::OFS_OSC_CTRL, 32'h00000000);
    clk_toggles();
    tick(2);
    chkb(lf_osc_en, 1'b0);
    @(posedge hclk);
    ts <= 1'b1;
    tick(2);
    chkb(lf_osc_en, 1'b1);
    @(posedge hclk);
    ts <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge hclk);
      tmr <= 3'h1 << i;
      tick(2);
      chkb(lf_osc_en, 1'b1);
      for (int k = 0; k < 5000 && lf_timebase !== 1'b1; k++) begin
        @(negedge hclk);
      end
      chkb(lf_timebase, 1'b1);
      @(posedge hclk);
      tmr <= 3'h0;
      tick(3);
      chkb(lf_osc_en, 1'b0);
    end
    // interrupts: gate closed, then each event, then masked
    pulse(3);
    tick(3);
    chkb(irq, 1'b0);
    rd_chk(iosc_pkg::OFS_IRQ_STAT, 32'h00000080);
    wr(iosc_pkg::OFS_IRQ_STAT, 32'h00000080);
    wr(iosc_pkg::OFS_IRQ_CTRL, 32'h00000040);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      tick(3);
      chkb(irq, 1'b1);
      rd_chk(iosc_pkg::OFS_IRQ_STAT, 32'h00000010 << i);
      wr(iosc_pkg::OFS_IRQ_STAT, 32'h00000010 << i);
      tick(2);
      chkb(irq, 1'b0);
    end
    wr(iosc_pkg::OFS_IRQ_EN, 32'h00000070);
    pulse(3);
    tick(3);
    chkb(irq, 1'b0);
    wr(iosc_pkg::OFS_IRQ_EN, 32'h000000F0);
    tick(2);
    chkb(irq, 1'b1);
    // second reset mid-run restores the defaults
    @(posedge hclk);
    hresetn <= 1'b0;
    tick(3);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(iosc_pkg::OFS_OSC_CTRL, 32'h00000060);
    rd_chk(iosc_pkg::OFS_IRQ_EN, 32'h00000000);
    give_verdict();
  end
endmodule
